// ---- core/sipo_regs.vh ----
// constants for the serial-in parallel-out latch block
`ifndef SIPO_REGS_VH
`define SIPO_REGS_VH
`define SIPO_WIDTH        8
`define SIPO_ZERO8        8'h00
`define SIPO_CNT_ZERO     2'h0
`define SIPO_CNT_ONE      2'h1
`define SIPO_CNT_TWO      2'h2
`define SIPO_ONE          1'h1
`define SIPO_NIL          1'h0
`endif

// ---- core/sipo_buf2.v ----
// two-entry valid/ready buffer for captured storage words
`timescale 1ns/10ps
`include "sipo_regs.vh"
`default_nettype none
module sipo_buf2 #(
    parameter WIDTH = 8
) (
    // clock and reset
    input  wire             mclk_i,
    input  wire             reset_n_i,
    // fill side
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    // drain side
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_reg [0:1];
    reg             rd_ptr_reg;
    reg             wr_ptr_reg;
    reg [1:0]       count_reg;
    wire            push;
    wire            pop;

    assign in_ready_o  = (count_reg != `SIPO_CNT_TWO);
    assign out_valid_o = (count_reg != `SIPO_CNT_ZERO);
    assign out_data_o  = mem_reg[rd_ptr_reg];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            rd_ptr_reg <= `SIPO_NIL;
            wr_ptr_reg <= `SIPO_NIL;
            count_reg  <= `SIPO_CNT_ZERO;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + `SIPO_CNT_ONE;
            end else if (pop & ~push) begin
                count_reg <= count_reg - `SIPO_CNT_ONE;
            end
        end
    end

    // data array needs no reset; valid gates it
    always @(posedge mclk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

// ---- core/sipo_latch8.v ----
// serial-in parallel-out shift chain with storage register and outputs
`timescale 1ns/10ps
`include "sipo_regs.vh"
`default_nettype none
module sipo_latch8 #(
    parameter WIDTH = `SIPO_WIDTH
) (
    // clock and reset
    input  wire             mclk_i,
    input  wire             reset_n_i,
    // host side inputs, synchronous to mclk_i
    input  wire             serial_in_i,
    input  wire             shift_clock_i,
    input  wire             shift_clear_n_i,
    input  wire             store_clock_i,
    input  wire             output_enable_n_i,
    // parallel outputs as three-state pairs, oe low means driven
    output reg  [WIDTH-1:0] parallel_out_o,
    output reg  [WIDTH-1:0] parallel_out_oe_n_o,
    // cascade output
    output reg              cascade_out_o,
    // stored word stream
    output reg              word_valid_o,
    input  wire             word_ready_i,
    output reg  [WIDTH-1:0] word_data_o
);
    reg  [WIDTH-1:0] chain_reg;
    reg  [WIDTH-1:0] chain_next;
    reg  [WIDTH-1:0] store_reg;
    reg              shift_clk_d_reg;
    reg              store_clk_d_reg;
    wire             shift_rise;
    wire             store_rise;
    wire             buf_in_ready;
    wire             buf_out_valid;
    wire [WIDTH-1:0] buf_out_data;
    wire             out_take;

    // edges found from the sampled host clocks
    assign shift_rise = shift_clock_i & ~shift_clk_d_reg;
    assign store_rise = store_clock_i & ~store_clk_d_reg;

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            shift_clk_d_reg <= `SIPO_NIL;
            store_clk_d_reg <= `SIPO_NIL;
        end else begin
            shift_clk_d_reg <= shift_clock_i;
            store_clk_d_reg <= store_clock_i;
        end
    end

    always @* begin
        chain_next = chain_reg;
        if (!shift_clear_n_i) begin
            chain_next = `SIPO_ZERO8;
        end else if (shift_rise) begin
            chain_next = {chain_reg[WIDTH-2:0], serial_in_i};
        end
    end

    // reset gives a defined start; software still must load data first
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            chain_reg <= `SIPO_ZERO8;
            store_reg <= `SIPO_ZERO8;
        end else begin
            chain_reg <= chain_next;
            // old chain_reg is read here, so a shared edge lags by one
            if (store_rise) begin
                store_reg <= chain_reg;
            end
        end
    end

    // parallel and cascade outputs registered from next values so they track without delay; oe lags output_enable_n_i by one cycle
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            parallel_out_o      <= `SIPO_ZERO8;
            parallel_out_oe_n_o <= {WIDTH{`SIPO_ONE}};
            cascade_out_o       <= `SIPO_NIL;
        end else begin
            parallel_out_o      <= store_rise ? chain_reg : store_reg;
            parallel_out_oe_n_o <= {WIDTH{output_enable_n_i}};
            cascade_out_o       <= chain_next[WIDTH-1];
        end
    end

    // a stalled receiver loses stored words: a store_rise while the buffer is full is dropped
    sipo_buf2 #(
        .WIDTH (WIDTH)
    ) u_buf (
        .mclk_i      (mclk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (store_rise),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (chain_reg),
        .out_valid_o (buf_out_valid),
        .out_ready_i (out_take),
        .out_data_o  (buf_out_data)
    );

    // output skid register so word outputs come from flip-flops
    assign out_take = buf_out_valid & (~word_valid_o | word_ready_i);

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            word_valid_o <= `SIPO_NIL;
            word_data_o  <= `SIPO_ZERO8;
        end else if (out_take) begin
            word_valid_o <= `SIPO_ONE;
            word_data_o  <= buf_out_data;
        end else if (word_ready_i) begin
            word_valid_o <= `SIPO_NIL;
        end
    end

    // overflow of the word stream is not flagged; buf_in_ready unused by host
    wire unused_ready;
    assign unused_ready = buf_in_ready;
endmodule
`default_nettype wire

// ---- bench/sipo_props.sv ----
// port checker for the latch block
`timescale 1ns/10ps
`default_nettype none
module sipo_props #(parameter WIDTH = 8) (
    input wire             mclk_i, reset_n_i, serial_in_i, shift_clock_i, shift_clear_n_i,
    input wire             store_clock_i, output_enable_n_i, cascade_out_o, word_valid_o,
    input wire             word_ready_i,
    input wire [WIDTH-1:0] parallel_out_o, parallel_out_oe_n_o, word_data_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    property p_oe; parallel_out_oe_n_o == {WIDTH{$past(output_enable_n_i)}}; endproperty
    a_oe: assert property (p_oe) else $error("enable copy");
    property p_clr; !shift_clear_n_i |=> !cascade_out_o; endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_cas; shift_clear_n_i && !$rose(shift_clock_i) |=> $stable(cascade_out_o); endproperty
    a_cas: assert property (p_cas) else $error("cascade moved");
    property p_par; !$rose(store_clock_i) |=> $stable(parallel_out_o); endproperty
    a_par: assert property (p_par) else $error("storage moved");
    property p_cp; $rose(store_clock_i) |=> parallel_out_o[WIDTH-1] == $past(cascade_out_o); endproperty
    a_cp: assert property (p_cp) else $error("store copy");
    property p_zc; $rose(store_clock_i) && !$past(shift_clear_n_i) |=> parallel_out_o == 0; endproperty
    a_zc: assert property (p_zc) else $error("cleared store");
    property p_hold; word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_data_o); endproperty
    a_hold: assert property (p_hold) else $error("word lost");
    property p_push; $rose(store_clock_i) && !word_valid_o |-> ##2 word_valid_o; endproperty
    a_push: assert property (p_push) else $error("word late");
endmodule
bind sipo_latch8 sipo_props #(.WIDTH(WIDTH)) props_u (.*);
`default_nettype wire

// ---- bench/sipo_sink.sv ----
// receiver model for the stored word stream
`timescale 1ns/10ps
`default_nettype none
module sipo_sink (
    input wire logic       mclk_i, stall_i, valid_i,
    input wire logic [7:0] data_i,
    output logic           ready_o,
    output int             count_o,
    output logic [7:0]     last_o
);
    assign ready_o = !stall_i;
    initial count_o = 0;
    always @(posedge mclk_i) begin
        if (valid_i && ready_o) begin
            count_o <= count_o + 1;
            last_o <= data_i;
        end
    end
endmodule
`default_nettype wire

// ---- bench/sipo_latch8_bench.sv ----
// bench for the latch block
`timescale 1ns/10ps
`default_nettype none
module sipo_latch8_bench;
    logic mclk_i = 0, reset_n_i = 0, serial_in = 0, shc = 0, clr = 1, stc = 0, oen = 1, stall = 0;
    wire [7:0] par, oe, wd, last;
    wire       cas, wv, rdy;
    int        num_errors = 0, n_tests = 0, cnt, c0;
    initial forever #2 mclk_i = ~mclk_i;
    sipo_latch8 dut_u (.mclk_i, .reset_n_i, .serial_in_i(serial_in), .shift_clock_i(shc),
        .shift_clear_n_i(clr), .store_clock_i(stc), .output_enable_n_i(oen),
        .parallel_out_o(par), .parallel_out_oe_n_o(oe), .cascade_out_o(cas),
        .word_valid_o(wv), .word_ready_i(rdy), .word_data_o(wd));
    sipo_sink sink_u (.mclk_i, .stall_i(stall), .valid_i(wv), .data_i(wd), .ready_o(rdy),
        .count_o(cnt), .last_o(last));
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    // clocks rise together, then drop for one cycle so the next rise is seen
    task pulse(input logic s, input logic c, input logic r);
        @(negedge mclk_i) begin serial_in = s; shc = c; stc = r; end
        @(negedge mclk_i) begin shc = 0; stc = 0; end
    endtask
    task t_load;
        @(negedge mclk_i) clr = 0;
        @(negedge mclk_i) clr = 1;
        for (int i = 7; i >= 0; i--) pulse(8'ha5 >> i, 1, 0);
        pulse(0, 0, 1);
        repeat (3) @(negedge mclk_i);
        chk("par", 8'ha5, par);
        chk("cas", 8'h01, {7'h00, cas});
        chk("word", 8'ha5, last);
    endtask
    task t_shared;
        pulse(0, 1, 1);
        @(negedge mclk_i);
        chk("par", 8'ha5, par);
        chk("cas", 8'h00, {7'h00, cas});
        clr = 0;
        repeat (2) @(negedge mclk_i);
        chk("par", 8'ha5, par);
        pulse(0, 0, 1);
        clr = 1;
        @(negedge mclk_i);
        chk("par", 8'h00, par);
    endtask
    task t_oe;
        oen = 0;
        repeat (2) @(negedge mclk_i);
        chk("oe", 8'h00, oe);
        oen = 1;
        repeat (2) @(negedge mclk_i);
        chk("oe", 8'hff, oe);
    endtask
    // four stores against a stalled receiver: only three fit
    task t_buf;
        stall = 1;
        c0 = cnt;
        repeat (4) pulse(1, 1, 1);
        @(negedge mclk_i);
        chk("par", 8'h07, par);
        stall = 0;
        repeat (8) @(negedge mclk_i);
        chk("count", 8'h03, 8'(cnt - c0));
        chk("word", 8'h03, last);
    endtask
    task stop_test;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge mclk_i);
        reset_n_i = 1;
        t_load();
        t_shared();
        t_oe();
        t_buf();
        stop_test();
    end
    initial begin
        #20000;
        num_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
